// >>> verilog/vpiu_defines.vh
// register offsets, field positions, reset values and timing counts of the interrupt unit
`ifndef VPIU_DEFINES_VH
`define VPIU_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define VPIU_OFS_FIP_HI 8'hD0
`define VPIU_OFS_FIP_LO 8'hD1
`define VPIU_OFS_PEND_HI 8'hD2
`define VPIU_OFS_PEND_LO 8'hD3
`define VPIU_OFS_STATUS 8'hD4
`define VPIU_OFS_REQUEST 8'hDC
`define VPIU_OFS_LEVEL_MASK 8'hDD
`define VPIU_OFS_SYS_MODE 8'hDE
`define VPIU_OFS_PRIO_ORDER 8'hFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VPIU_SMR_GIE 0
`define VPIU_SMR_FAST_EN 1
`define VPIU_SMR_FSEL_LO 2
`define VPIU_IPR_GROUP_HI 2
`define VPIU_IPR_PAIR_A 3
`define VPIU_IPR_B_SWAP 4
`define VPIU_IPR_B_LAST 5
`define VPIU_IPR_C_SWAP 6
`define VPIU_IPR_C_LAST 7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VPIU_RST_LEVEL_MASK 8'h00
`define VPIU_RST_SYS_MODE 8'h00
`define VPIU_RST_PRIO_ORDER 8'h00
`define VPIU_RST_FIP 16'h0000

// ----------------------------------------------------------------
// sizes and timing counts (clock periods)
// ----------------------------------------------------------------
`define VPIU_NUM_SRC 27
`define VPIU_NUM_INT 11
`define VPIU_NUM_EXT 16
`define VPIU_NUM_VEC 16
`define VPIU_NUM_LVL 8
`define VPIU_NORMAL_ENTRY_CYC 5'd22
`define VPIU_FAST_ENTRY_CYC 5'd6
`define VPIU_RET_LAST_CNT 5'd4

`endif

// >>> verilog/vpiu_ctrl.v
// vectored priority interrupt unit: sources, levels, priority, entry and return sequencing
`timescale 1ns/1ps
`include "vpiu_defines.vh"

module vpiu_ctrl (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// interrupt sources
	input wire [10:0] int_req,
	input wire [15:0] ext_pin,
	input wire [26:0] src_en,
	// core events
	input wire instr_end,
	input wire ei_exec,
	input wire di_exec,
	input wire return_from_interrupt_instr_exec,
	input wire [15:0] pc_in,
	input wire [7:0] flags_in,
	// core sequencing
	output wire cpu_hold,
	output reg stack_push,
	output reg [15:0] push_data,
	output reg stack_pop,
	input wire [15:0] pop_data,
	output reg vec_rd,
	output reg [15:0] vec_addr,
	input wire [7:0] vec_data,
	output reg pc_load,
	output reg [15:0] pc_value,
	output reg flags_load,
	output reg [7:0] flags_value,
	output reg fast_status_bit
);

// ----------------------------------------------------------------
// static maps
// ----------------------------------------------------------------
localparam S_IDLE = 4'b0001;
localparam S_NORM = 4'b0010;
localparam S_FAST = 4'b0100;
localparam S_RET = 4'b1000;

// internal sources 0..10, pin sources 11..26
function [3:0] src_vec;
	input integer s;
	begin
		case (s)
		0, 9, 10: src_vec = 4'h8;
		1: src_vec = 4'h9;
		2: src_vec = 4'hA;
		3: src_vec = 4'hC;
		4: src_vec = 4'hD;
		5: src_vec = 4'h6;
		6: src_vec = 4'h7;
		7: src_vec = 4'hE;
		8: src_vec = 4'hF;
		11: src_vec = 4'h2;
		12: src_vec = 4'h3;
		13: src_vec = 4'h4;
		14: src_vec = 4'h5;
		15, 16: src_vec = 4'h6;
		17, 18: src_vec = 4'h7;
		19: src_vec = 4'hA;
		20: src_vec = 4'hB;
		21: src_vec = 4'hC;
		22: src_vec = 4'hD;
		23, 24: src_vec = 4'hE;
		default: src_vec = 4'hF;
		endcase
	end
endfunction

// vector index v sits at byte address 2v
function [2:0] vec_lvl;
	input integer v;
	begin
		case (v)
		4, 5: vec_lvl = 3'h0;
		12, 13: vec_lvl = 3'h1;
		6: vec_lvl = 3'h2;
		14: vec_lvl = 3'h4;
		7: vec_lvl = 3'h5;
		8, 9, 10, 11: vec_lvl = 3'h6;
		15: vec_lvl = 3'h7;
		default: vec_lvl = 3'h3;
		endcase
	end
endfunction

// ----------------------------------------------------------------
// reset release and pin synchronisers
// ----------------------------------------------------------------
reg rst_meta;
reg rst_n;
reg [15:0] pin_s1;
reg [15:0] pin_s2;
reg [15:0] pin_s3;

always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		rst_meta <= 1'b0;
		rst_n <= 1'b0;
	end else begin
		rst_meta <= 1'b1;
		rst_n <= rst_meta;
	end
end

always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		pin_s1 <= 16'h0000;
		pin_s2 <= 16'h0000;
		pin_s3 <= 16'h0000;
	end else begin
		pin_s1 <= ext_pin;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end
end

// ----------------------------------------------------------------
// registers and state
// ----------------------------------------------------------------
reg [7:0] level_mask;
reg [7:0] system_mode_control;
reg [7:0] level_priority_order;
reg [7:0] irq_snap;
reg [15:0] ext_pend;
reg [15:0] fast_instruction_pointer;
reg [7:0] shadow_flags;
reg [3:0] state;
reg [4:0] cnt;
reg [3:0] grant_vec;
reg [15:0] ret_pc;
reg [7:0] ret_flags;
reg [7:0] vec_hi;
reg [15:0] vec_pc;

wire gie = system_mode_control[`VPIU_SMR_GIE];
wire fast_en = system_mode_control[`VPIU_SMR_FAST_EN];
wire [2:0] fast_sel = system_mode_control[`VPIU_SMR_FSEL_LO +: 3];
wire [15:0] pin_fall = pin_s3 & ~pin_s2;
wire wr_pend_hi = reg_wr && (reg_addr == `VPIU_OFS_PEND_HI);
wire wr_pend_lo = reg_wr && (reg_addr == `VPIU_OFS_PEND_LO);
wire [15:0] pend_clr = {wr_pend_hi ? reg_wdata : 8'h00, wr_pend_lo ? reg_wdata : 8'h00};

// ----------------------------------------------------------------
// request gathering
// ----------------------------------------------------------------
wire [26:0] src_act = {ext_pend, int_req} & src_en;
wire [15:0] vec_req;
wire [7:0] level_req;

genvar gv;
generate
	for (gv = 0; gv < `VPIU_NUM_VEC; gv = gv + 1) begin : g_vec
		reg [26:0] sel;
		integer s;
		always @* begin
			sel = 27'h000_0000;
			for (s = 0; s < `VPIU_NUM_SRC; s = s + 1) begin
				sel[s] = (src_vec(s) == gv);
			end
		end
		// reserved pairs have no source mapped onto them
		assign vec_req[gv] = (gv > 1) && |(src_act & sel);
	end
	for (gv = 0; gv < `VPIU_NUM_LVL; gv = gv + 1) begin : g_lvl
		reg [15:0] sel;
		integer v;
		always @* begin
			sel = 16'h0000;
			for (v = 0; v < `VPIU_NUM_VEC; v = v + 1) begin
				sel[v] = (vec_lvl(v) == gv);
			end
		end
		assign level_req[gv] = |(vec_req & sel);
	end
endgenerate

// ----------------------------------------------------------------
// level ordering: 6 group orders x 2 x 4 x 4 = 192 codes
// ----------------------------------------------------------------
reg [5:0] grp_a;
reg [5:0] tail_b;
reg [5:0] tail_c;
reg [8:0] grp_b;
reg [8:0] grp_c;
reg [23:0] order;

always @* begin
	grp_a = level_priority_order[`VPIU_IPR_PAIR_A] ? {3'd0, 3'd1} : {3'd1, 3'd0};
	tail_b = level_priority_order[`VPIU_IPR_B_SWAP] ? {3'd3, 3'd4} : {3'd4, 3'd3};
	tail_c = level_priority_order[`VPIU_IPR_C_SWAP] ? {3'd6, 3'd7} : {3'd7, 3'd6};
	grp_b = level_priority_order[`VPIU_IPR_B_LAST] ? {3'd2, tail_b} : {tail_b, 3'd2};
	grp_c = level_priority_order[`VPIU_IPR_C_LAST] ? {3'd5, tail_c} : {tail_c, 3'd5};
	// first place in the low bits; codes 6 and 7 fall back to code 0
	case (level_priority_order[`VPIU_IPR_GROUP_HI:0])
	3'd1: order = {grp_b, grp_c, grp_a};
	3'd2: order = {grp_c, grp_a, grp_b};
	3'd3: order = {grp_a, grp_c, grp_b};
	3'd4: order = {grp_b, grp_a, grp_c};
	3'd5: order = {grp_a, grp_b, grp_c};
	default: order = {grp_c, grp_b, grp_a};
	endcase
end

// ----------------------------------------------------------------
// winner selection
// ----------------------------------------------------------------
wire [7:0] level_ok = level_req & level_mask & {8{gie}};
reg win_found;
reg [2:0] win_lvl;
reg [3:0] win_vec;
integer p;
integer v;

always @* begin
	win_found = 1'b0;
	win_lvl = 3'd0;
	win_vec = 4'd0;
	// scanned from the bottom so the last hit is the top place
	for (p = `VPIU_NUM_LVL - 1; p >= 0; p = p - 1) begin
		if (level_ok[order[p*3 +: 3]]) begin
			win_found = 1'b1;
			win_lvl = order[p*3 +: 3];
		end
	end
	for (v = `VPIU_NUM_VEC - 1; v >= 2; v = v - 1) begin
		if (vec_req[v] && (vec_lvl(v) == win_lvl)) begin
			win_vec = v[3:0];
		end
	end
end

wire is_idle = (state == S_IDLE);
wire grant = is_idle && instr_end && !return_from_interrupt_instr_exec && win_found;
wire grant_fast = fast_en && (win_lvl == fast_sel);
wire fast_ret = is_idle && return_from_interrupt_instr_exec && fast_status_bit;
wire norm_ret = is_idle && return_from_interrupt_instr_exec && !fast_status_bit;
assign cpu_hold = !is_idle;

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		level_mask <= `VPIU_RST_LEVEL_MASK;
		level_priority_order <= `VPIU_RST_PRIO_ORDER;
		irq_snap <= 8'h00;
		ext_pend <= 16'h0000;
	end else begin
		if (reg_wr && (reg_addr == `VPIU_OFS_LEVEL_MASK)) begin
			level_mask <= reg_wdata;
		end
		if (reg_wr && (reg_addr == `VPIU_OFS_PRIO_ORDER)) begin
			level_priority_order <= reg_wdata;
		end
		// raw levels, masked or not; a write here does nothing
		if (instr_end) begin
			irq_snap <= level_req;
		end
		// a new edge wins over a clear in the same cycle
		ext_pend <= (ext_pend & ~pend_clr) | pin_fall;
	end
end

always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		case (reg_addr)
		`VPIU_OFS_FIP_HI: reg_rdata <= fast_instruction_pointer[15:8];
		`VPIU_OFS_FIP_LO: reg_rdata <= fast_instruction_pointer[7:0];
		`VPIU_OFS_PEND_HI: reg_rdata <= ext_pend[15:8];
		`VPIU_OFS_PEND_LO: reg_rdata <= ext_pend[7:0];
		`VPIU_OFS_STATUS: reg_rdata <= {6'h00, cpu_hold, fast_status_bit};
		`VPIU_OFS_REQUEST: reg_rdata <= irq_snap;
		`VPIU_OFS_LEVEL_MASK: reg_rdata <= level_mask;
		`VPIU_OFS_SYS_MODE: reg_rdata <= system_mode_control;
		`VPIU_OFS_PRIO_ORDER: reg_rdata <= level_priority_order;
		default: reg_rdata <= 8'h00;
		endcase
	end else begin
		reg_rdata <= 8'h00;
	end
end

// ----------------------------------------------------------------
// entry and return sequencer
// ----------------------------------------------------------------
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		state <= S_IDLE;
		cnt <= 5'd0;
		system_mode_control <= `VPIU_RST_SYS_MODE;
		fast_status_bit <= 1'b0;
		fast_instruction_pointer <= `VPIU_RST_FIP;
		shadow_flags <= 8'h00;
		grant_vec <= 4'd0;
		ret_pc <= 16'h0000;
		ret_flags <= 8'h00;
		vec_hi <= 8'h00;
		vec_pc <= 16'h0000;
		stack_push <= 1'b0;
		push_data <= 16'h0000;
		stack_pop <= 1'b0;
		vec_rd <= 1'b0;
		vec_addr <= 16'h0000;
		pc_load <= 1'b0;
		pc_value <= 16'h0000;
		flags_load <= 1'b0;
		flags_value <= 8'h00;
	end else begin
		stack_push <= 1'b0;
		stack_pop <= 1'b0;
		vec_rd <= 1'b0;
		pc_load <= 1'b0;
		flags_load <= 1'b0;
		// software writes first; hardware events below override them
		if (reg_wr && (reg_addr == `VPIU_OFS_SYS_MODE)) begin
			system_mode_control <= reg_wdata;
		end
		if (reg_wr && (reg_addr == `VPIU_OFS_FIP_HI)) begin
			fast_instruction_pointer[15:8] <= reg_wdata;
		end
		if (reg_wr && (reg_addr == `VPIU_OFS_FIP_LO)) begin
			fast_instruction_pointer[7:0] <= reg_wdata;
		end
		if (ei_exec) begin
			system_mode_control[`VPIU_SMR_GIE] <= 1'b1;
		end
		if (di_exec) begin
			system_mode_control[`VPIU_SMR_GIE] <= 1'b0;
		end
		case (state)
		S_IDLE: begin
			cnt <= 5'd0;
			if (fast_ret) begin
				pc_load <= 1'b1;
				pc_value <= fast_instruction_pointer;
				fast_instruction_pointer <= pc_in;
				flags_load <= 1'b1;
				flags_value <= shadow_flags;
				fast_status_bit <= 1'b0;
				system_mode_control[`VPIU_SMR_GIE] <= 1'b1;
			end else if (norm_ret) begin
				state <= S_RET;
			end else if (grant) begin
				system_mode_control[`VPIU_SMR_GIE] <= 1'b0;
				grant_vec <= win_vec;
				ret_pc <= pc_in;
				ret_flags <= flags_in;
				state <= grant_fast ? S_FAST : S_NORM;
			end
		end
		S_NORM: begin
			cnt <= cnt + 5'd1;
			if (cnt == 5'd0) begin
				stack_push <= 1'b1;
				push_data <= ret_pc;
			end
			if (cnt == 5'd1) begin
				stack_push <= 1'b1;
				push_data <= {8'h00, ret_flags};
			end
			if (cnt == 5'd2 || cnt == 5'd3) begin
				vec_rd <= 1'b1;
				vec_addr <= {11'h000, grant_vec, cnt[0]};
			end
			if (cnt == 5'd4) begin
				vec_hi <= vec_data;
			end
			if (cnt == 5'd5) begin
				vec_pc <= {vec_hi, vec_data};
			end
			// the sequence spans 22 clocks counting the grant cycle
			if (cnt == `VPIU_NORMAL_ENTRY_CYC - 5'd3) begin
				pc_load <= 1'b1;
				pc_value <= vec_pc;
			end
			if (cnt == `VPIU_NORMAL_ENTRY_CYC - 5'd2) begin
				state <= S_IDLE;
			end
		end
		S_FAST: begin
			cnt <= cnt + 5'd1;
			if (cnt == `VPIU_FAST_ENTRY_CYC - 5'd3) begin
				pc_load <= 1'b1;
				pc_value <= fast_instruction_pointer;
				fast_instruction_pointer <= ret_pc;
				shadow_flags <= ret_flags;
				fast_status_bit <= 1'b1;
			end
			if (cnt == `VPIU_FAST_ENTRY_CYC - 5'd2) begin
				state <= S_IDLE;
			end
		end
		S_RET: begin
			cnt <= cnt + 5'd1;
			// flags were pushed last, so they come back first
			if (cnt == 5'd0 || cnt == 5'd1) begin
				stack_pop <= 1'b1;
			end
			if (cnt == 5'd2) begin
				flags_value <= pop_data[7:0];
			end
			if (cnt == 5'd3) begin
				pc_value <= pop_data;
				pc_load <= 1'b1;
				flags_load <= 1'b1;
				system_mode_control[`VPIU_SMR_GIE] <= 1'b1;
			end
			if (cnt == `VPIU_RET_LAST_CNT) begin
				state <= S_IDLE;
			end
		end
		default: begin
			state <= S_IDLE;
		end
		endcase
	end
end

endmodule // vpiu_ctrl

// >>> test/vpiu_ctrl_sva.sv
// port-level timing checks of the interrupt unit
`timescale 1ns/1ps
module vpiu_ctrl_sva (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// core events
	input wire instr_end,
	input wire ei_exec,
	input wire di_exec,
	input wire return_from_interrupt_instr_exec,
	input wire [15:0] pc_in,
	input wire [7:0] flags_in,
	// core sequencing
	input wire cpu_hold,
	input wire stack_push,
	input wire [15:0] push_data,
	input wire stack_pop,
	input wire vec_rd,
	input wire [15:0] vec_addr,
	input wire [7:0] vec_data,
	input wire pc_load,
	input wire [15:0] pc_value,
	input wire flags_load,
	input wire fast_status_bit
);
	reg gie_m;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// --------------------------------
	// global enable mirror
	// --------------------------------
	// return_from_interrupt_instr sets it early; harmless because grants are ignored while held
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gie_m <= 1'b0;
		end else if (ei_exec || return_from_interrupt_instr_exec) begin
			gie_m <= 1'b1;
		end else if (di_exec || ($rose(cpu_hold) && !$past(return_from_interrupt_instr_exec))) begin
			gie_m <= 1'b0;
		end else if (reg_wr && reg_addr == 8'hde) begin
			gie_m <= reg_wdata[0];
		end
	end
	// --------------------------------
	// assertions
	// --------------------------------
	gie_block_a: assert property (!gie_m && instr_end && !cpu_hold && !return_from_interrupt_instr_exec |=> !cpu_hold)
		else $error("grant while globally disabled");
	hold_cause_a: assert property ($rose(cpu_hold) |-> $past(instr_end) || $past(return_from_interrupt_instr_exec))
		else $error("hold started off a boundary");
	normal_entry_a: assert property ($rose(cpu_hold) ##1 stack_push |-> ##19 pc_load ##1 !cpu_hold)
		else $error("normal entry length wrong");
	fast_entry_a: assert property (($rose(cpu_hold) && !$past(return_from_interrupt_instr_exec)) ##1 !stack_push
		|-> ##3 (pc_load && !flags_load) ##1 (!cpu_hold && fast_status_bit))
		else $error("fast entry wrong");
	push_order_a: assert property ($rose(cpu_hold) ##1 stack_push |-> push_data == $past(pc_in, 2)
		##1 (stack_push && push_data == {8'h00, $past(flags_in, 3)}))
		else $error("push sequence wrong");
	vec_pair_a: assert property (vec_rd && !$past(vec_rd) |-> vec_addr[0] == 1'b0
		&& vec_addr >= 16'h0004 && vec_addr <= 16'h001e
		##1 (vec_rd && vec_addr == $past(vec_addr) + 16'h0001))
		else $error("vector pair address wrong");
	vec_load_a: assert property (vec_rd ##1 vec_rd
		|-> ##16 (pc_load && pc_value == {$past(vec_data, 16), $past(vec_data, 15)}))
		else $error("service address wrong");
	fast_ret_a: assert property (return_from_interrupt_instr_exec && fast_status_bit && !cpu_hold
		|=> (pc_load && flags_load && !cpu_hold) ##1 !fast_status_bit)
		else $error("fast return wrong");
	norm_ret_a: assert property (return_from_interrupt_instr_exec && !fast_status_bit && !cpu_hold
		|=> cpu_hold ##1 stack_pop ##1 stack_pop ##2 (pc_load && flags_load) ##1 !cpu_hold)
		else $error("normal return wrong");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
endmodule // vpiu_ctrl_sva

bind vpiu_ctrl vpiu_ctrl_sva vpiu_ctrl_sva_i (.core_clk, .reset_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .instr_end, .ei_exec, .di_exec, .return_from_interrupt_instr_exec, .pc_in,
	.flags_in, .cpu_hold, .stack_push, .push_data, .stack_pop, .vec_rd, .vec_addr,
	.vec_data, .pc_load, .pc_value, .flags_load, .fast_status_bit);

// >>> test/vpiu_core_model.sv
// processor core model: boundaries, pc and flags, stack and vector memory
`timescale 1ns/1ps
module vpiu_core_model (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// control from the bench
	input wire run,
	// sequencing from the unit
	input wire cpu_hold,
	input wire stack_push,
	input wire [15:0] push_data,
	input wire stack_pop,
	input wire vec_rd,
	input wire [15:0] vec_addr,
	input wire pc_load,
	input wire [15:0] pc_value,
	input wire flags_load,
	input wire [7:0] flags_value,
	// answers to the unit
	output reg instr_end,
	output reg [15:0] pc_in,
	output reg [7:0] flags_in,
	output reg [15:0] pop_data,
	output reg [7:0] vec_data
);
	reg [15:0] stk [0:7];
	reg [2:0] sp;
	reg [1:0] cnt;
	// data not being answered is inverted each cycle so a late sample is caught
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			instr_end <= 1'b0;
			cnt <= 2'h0;
			sp <= 3'h0;
			pc_in <= 16'h0100;
			flags_in <= 8'h3c;
			pop_data <= 16'h0000;
			vec_data <= 8'h00;
		end else begin
			cnt <= cnt + 2'h1;
			instr_end <= run && !cpu_hold && cnt == 2'h3;
			if (pc_load) begin
				pc_in <= pc_value;
			end
			if (flags_load) begin
				flags_in <= flags_value;
			end
			vec_data <= vec_rd ? vec_addr[7:0] + 8'h40 : ~vec_data;
			if (stack_push) begin
				stk[sp] <= push_data;
				sp <= sp + 3'h1;
			end
			if (stack_pop) begin
				pop_data <= stk[sp - 3'h1];
				sp <= sp - 3'h1;
			end else begin
				pop_data <= ~pop_data;
			end
		end
	end
endmodule // vpiu_core_model

// >>> test/tb_top.sv
// self-checking bench of the interrupt unit
`timescale 1ns/1ps
module tb_top;
	reg core_clk, reset_n, reg_wr, reg_rd, ei_exec, di_exec, return_from_interrupt_instr_exec, run, hp;
	reg [7:0] reg_addr, reg_wdata, rv, last_fl;
	reg [10:0] int_req;
	reg [15:0] ext_pin, last_pc;
	reg [26:0] src_en;
	wire [7:0] reg_rdata, flags_in, vec_data, flags_value;
	wire [15:0] pc_in, push_data, pop_data, vec_addr, pc_value;
	wire instr_end, cpu_hold, stack_push, stack_pop, vec_rd, pc_load, flags_load, fast_status_bit;
	integer num_errors, n_checks, hcnt, h0;

	vpiu_ctrl vpiu_ctrl_i (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .int_req, .ext_pin, .src_en, .instr_end, .ei_exec, .di_exec, .return_from_interrupt_instr_exec,
		.pc_in, .flags_in, .cpu_hold, .stack_push, .push_data, .stack_pop, .pop_data, .vec_rd,
		.vec_addr, .vec_data, .pc_load, .pc_value, .flags_load, .flags_value, .fast_status_bit);
	vpiu_core_model vpiu_core_model_i (.core_clk, .reset_n, .run, .cpu_hold, .stack_push,
		.push_data, .stack_pop, .vec_rd, .vec_addr, .pc_load, .pc_value, .flags_load,
		.flags_value, .instr_end, .pc_in, .flags_in, .pop_data, .vec_data);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			hp <= 1'b0;
			hcnt <= 0;
			last_pc <= 16'h0000;
			last_fl <= 8'h00;
		end else begin
			hp <= cpu_hold;
			if (cpu_hold === 1'b1 && hp !== 1'b1) hcnt <= hcnt + 1;
			if (pc_load === 1'b1) last_pc <= pc_value;
			if (flags_load === 1'b1) last_fl <= flags_value;
		end
	end
	// --------------------------------
	// shared tasks
	// --------------------------------
	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge core_clk);
			reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
			@(posedge core_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge core_clk);
			reg_rd <= 1'b1; reg_addr <= a;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			// read data stand only in the cycle after the strobe
			@(posedge core_clk);
			rv = reg_rdata;
		end
	endtask
	task pulse(input [2:0] w);
		begin
			@(posedge core_clk);
			{ei_exec, di_exec, return_from_interrupt_instr_exec} <= w;
			@(posedge core_clk);
			{ei_exec, di_exec, return_from_interrupt_instr_exec} <= 3'h0;
		end
	endtask
	task waith(input v);
		integer i;
		begin
			i = 0;
			while (cpu_hold !== v && i < 100) begin
				@(posedge core_clk);
				i = i + 1;
			end
			chk(cpu_hold, v);
		end
	endtask
	task serve(input [15:0] e);
		begin
			waith(1'b1);
			waith(1'b0);
			chk(last_pc, e);
		end
	endtask
	// boundaries stop during the return so a new grant cannot hide it
	task ret(input [15:0] e);
		begin
			@(posedge core_clk);
			run <= 1'b0;
			pulse(3'b001);
			repeat (8) @(posedge core_clk);
			chk(last_pc, e);
			chk(last_fl, 8'h3c);
			run <= 1'b1;
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, num_errors);
			if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task t_regs;
		begin
			rd(8'hdd); chk(rv, 8'h00);
			rd(8'hde); chk(rv, 8'h00);
			chk(fast_status_bit, 1'b0);
			wr(8'hdc, 8'hff); rd(8'hdc); chk(rv, 8'h00);
			rd(8'h10); chk(rv, 8'h00);
			wr(8'hff, 8'h6b); rd(8'hff); chk(rv, 8'h6b);
			wr(8'hff, 8'h00);
			$display("register test done");
		end
	endtask
	task t_normal;
		begin
			wr(8'hdd, 8'h00); int_req[1] <= 1'b1; pulse(3'b100);
			repeat (12) @(posedge core_clk);
			chk(hcnt, 0);
			rd(8'hdc); chk(rv, 8'h40);
			src_en[1] <= 1'b0; wr(8'hdd, 8'hff);
			repeat (12) @(posedge core_clk);
			chk(hcnt, 0);
			src_en[1] <= 1'b1;
			serve(16'h5253);
			rd(8'hde); chk(rv, 8'h00);
			int_req[1] <= 1'b0; ret(16'h0100);
			rd(8'hde); chk(rv, 8'h01);
			$display("normal test done");
		end
	endtask
	task t_prio;
		begin
			pulse(3'b010); h0 = hcnt; int_req[3] <= 1'b1; int_req[0] <= 1'b1;
			repeat (12) @(posedge core_clk);
			chk(hcnt, h0);
			pulse(3'b100); serve(16'h5859);
			wr(8'hff, 8'h04); int_req[1] <= 1'b1; ret(16'h0100);
			serve(16'h5051);
			int_req <= 11'h000; ret(16'h0100);
			wr(8'hff, 8'h00);
			$display("priority test done");
		end
	endtask
	task t_nest;
		begin
			int_req[0] <= 1'b1; serve(16'h5051);
			rd(8'hdd); chk(rv, 8'hff);
			wr(8'hdd, 8'h3f); pulse(3'b100);
			int_req[3] <= 1'b1; serve(16'h5859);
			int_req[3] <= 1'b0; ret(16'h5051);
			pulse(3'b010); wr(8'hdd, 8'hff);
			int_req[0] <= 1'b0; ret(16'h0100);
			rd(8'hde); chk(rv, 8'h01);
			$display("nesting test done");
		end
	endtask
	task t_fast;
		begin
			wr(8'hd0, 8'h12); wr(8'hd1, 8'h34);
			wr(8'hde, 8'h06); int_req[3] <= 1'b1; pulse(3'b100);
			serve(16'h1234);
			chk(fast_status_bit, 1'b1);
			rd(8'hd0); chk(rv, 8'h01); rd(8'hd1); chk(rv, 8'h00);
			int_req[3] <= 1'b0; ret(16'h0100);
			chk(fast_status_bit, 1'b0);
			rd(8'hd0); chk(rv, 8'h12); rd(8'hd1); chk(rv, 8'h34);
			int_req[1] <= 1'b1; serve(16'h5253);
			int_req[1] <= 1'b0; ret(16'h0100);
			$display("fast test done");
		end
	endtask
	task t_pin;
		begin
			wr(8'hdd, 8'h00); ext_pin[0] <= 1'b0;
			repeat (6) @(posedge core_clk);
			rd(8'hd3); chk(rv, 8'h01);
			wr(8'hd3, 8'h01); rd(8'hd3); chk(rv, 8'h00);
			ext_pin[0] <= 1'b1;
			repeat (6) @(posedge core_clk);
			rd(8'hd3); chk(rv, 8'h00);
			ext_pin[0] <= 1'b0;
			repeat (6) @(posedge core_clk);
			ext_pin[0] <= 1'b1;
			repeat (6) @(posedge core_clk);
			rd(8'hd3); chk(rv, 8'h01);
			wr(8'hdd, 8'h08); serve(16'h4445);
			wr(8'hd3, 8'h01); ret(16'h0100);
			$display("pin test done");
		end
	endtask
	initial begin
		reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
		int_req = 11'h000; ext_pin = 16'hffff; src_en = {27{1'b1}}; run = 1'b0;
		ei_exec = 1'b0; di_exec = 1'b0; return_from_interrupt_instr_exec = 1'b0;
		num_errors = 0; n_checks = 0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		run <= 1'b1;
		t_regs;
		t_normal;
		t_prio;
		t_nest;
		t_fast;
		t_pin;
		stop_test;
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		num_errors = num_errors + 1;
		stop_test;
	end
endmodule // tb_top
